// File: hdl/mict_consts.svh
`ifndef MICT_CONSTS_SVH
`define MICT_CONSTS_SVH
// ----------------------------------------------------------------------
// timing, addresses and reset values
// ----------------------------------------------------------------------
`define MICT_CLK_PER_ICYC 4
`define MICT_PC_RST 13'h0000
`define MICT_PCL_ADDR 8'h06
`define MICT_SECTOR0 2'h0
`define MICT_GIE_RST 1'b0
`define MICT_CARRY_RST 1'b0
`endif

// File: hdl/mict_pkg.sv
package mict_pkg;
  // instruction classes decoded by the sequencer
  typedef enum logic [4:0] {
    MICT_OP_NOP, MICT_OP_ADD, MICT_OP_SUB, MICT_OP_AND, MICT_OP_OR,
    MICT_OP_XOR, MICT_OP_CPL, MICT_OP_INC, MICT_OP_DEC, MICT_OP_RR,
    MICT_OP_RL, MICT_OP_RRC, MICT_OP_RLC, MICT_OP_BSET, MICT_OP_BCLR,
    MICT_OP_MOVM, MICT_OP_JMP, MICT_OP_CALL, MICT_OP_RET, MICT_OP_INTERRUPT_RETURN_INSTR,
    MICT_OP_TBRD, MICT_OP_SZ, MICT_OP_SNZ
  } mict_op_t;
  typedef enum logic [0:0] {MICT_ST_EXEC, MICT_ST_FLUSH} mict_state_t;
endpackage : mict_pkg

// File: hdl/mict_alu_if.sv
`timescale 1ns/1ps
interface mict_alu_if;
  import mict_pkg::*;
  mict_op_t op;
  logic [7:0] acc;
  logic [7:0] mem;
  logic [2:0] bit_sel;
  logic carry_in;
  logic [7:0] result;
  logic carry_out;
  logic carry_upd;
  logic zero_out;
  logic zero_upd;
  modport core (output op, acc, mem, bit_sel, carry_in,
    input result, carry_out, carry_upd, zero_out, zero_upd);
  modport alu (input op, acc, mem, bit_sel, carry_in,
    output result, carry_out, carry_upd, zero_out, zero_upd);
endinterface : mict_alu_if

// File: hdl/mict_alu.sv
`timescale 1ns/1ps
module mict_alu
  import mict_pkg::*;
(
  mict_alu_if.alu a
);
  // --------------------------------------------------------------------
  // arithmetic
  // --------------------------------------------------------------------
  wire [8:0] sum = {1'b0, a.acc} + {1'b0, a.mem}; // [RQ6]
  wire [8:0] dif = {1'b0, a.acc} - {1'b0, a.mem}; // [RQ6]
  wire [7:0] bmask = 8'h01 << a.bit_sel;
  wire is_logic = (a.op == MICT_OP_AND) || (a.op == MICT_OP_OR) ||
    (a.op == MICT_OP_XOR) || (a.op == MICT_OP_CPL);
  // result select; bit ops touch only the chosen bit
  assign a.result =
    (a.op == MICT_OP_ADD) ? sum[7:0] :
    (a.op == MICT_OP_SUB) ? dif[7:0] :
    (a.op == MICT_OP_AND) ? (a.acc & a.mem) : // [RQ5]
    (a.op == MICT_OP_OR) ? (a.acc | a.mem) :
    (a.op == MICT_OP_XOR) ? (a.acc ^ a.mem) :
    (a.op == MICT_OP_CPL) ? ~a.mem :
    (a.op == MICT_OP_INC) ? a.mem + 8'h01 : // [RQ7]
    (a.op == MICT_OP_DEC) ? a.mem - 8'h01 : // [RQ7]
    (a.op == MICT_OP_RR) ? {a.mem[0], a.mem[7:1]} : // [RQ8]
    (a.op == MICT_OP_RL) ? {a.mem[6:0], a.mem[7]} :
    (a.op == MICT_OP_RRC) ? {a.carry_in, a.mem[7:1]} :
    (a.op == MICT_OP_RLC) ? {a.mem[6:0], a.carry_in} :
    (a.op == MICT_OP_BSET) ? (a.mem | bmask) : // [RQ9]
    (a.op == MICT_OP_BCLR) ? (a.mem & ~bmask) : // [RQ9]
    (a.op == MICT_OP_MOVM) ? a.acc : a.mem;
  // flags; subtract carry is not-borrow
  assign a.carry_out =
    (a.op == MICT_OP_ADD) ? sum[8] :
    (a.op == MICT_OP_SUB) ? ~dif[8] :
    (a.op == MICT_OP_RRC) ? a.mem[0] : a.mem[7]; // [RQ8]
  assign a.carry_upd = (a.op == MICT_OP_ADD) || (a.op == MICT_OP_SUB) ||
    (a.op == MICT_OP_RRC) || (a.op == MICT_OP_RLC);
  assign a.zero_out = (a.result == 8'h00); // [RQ5]
  assign a.zero_upd = is_logic || (a.op == MICT_OP_ADD) ||
    (a.op == MICT_OP_SUB) || (a.op == MICT_OP_INC) ||
    (a.op == MICT_OP_DEC);
endmodule : mict_alu

// File: hdl/mict_core.sv
`timescale 1ns/1ps
`include "mict_consts.svh"
// Behaviour
// [RQ1] four clocks per instruction cycle, advance at boundary
// [RQ2] branch, call, table read take two cycles
// [RQ3] writing program counter low byte adds cycle
// [RQ4] taken skip costs one extra cycle
// [RQ5] logic ops set zero on zero result
// [RQ6] carry above 255, borrow below 0
// [RQ7] increment and decrement change by one
// [RQ8] rotates one bit, through-carry uses carry
// [RQ9] bit set/clear is read-modify-write
// [RQ10] call saves return point, jump saves nothing
// [RQ11] table read delivers program memory data
// [RQ12] data accesses target sector 0
// [RQ13] interrupt return sets global enable
// [RQ14] extra cycle discards prefetched instruction
module mict_core
  import mict_pkg::*;
#(
  parameter int PC_W = 13,
  parameter int STACK_D = 8
)(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // decoded instruction from fetch
  input wire mict_op_t instr_op,
  input wire logic [7:0] instr_addr,
  input wire logic [7:0] instr_imm,
  input wire logic [2:0] instr_bit,
  input wire logic instr_use_imm,
  input wire logic instr_to_acc,
  input wire logic [PC_W-1:0] instr_target,
  // data memory port
  input wire logic [7:0] dmem_rdata,
  output logic [7:0] dmem_addr,
  output logic [1:0] dmem_sector,
  output logic [7:0] dmem_wdata,
  output logic dmem_we,
  // table read port
  input wire logic [7:0] tbl_rdata,
  output logic [PC_W-1:0] tbl_addr,
  // program fetch and status
  output logic [PC_W-1:0] pc,
  output logic icyc_strobe,
  output logic flush,
  output logic [7:0] acc,
  output logic carry,
  output logic zero,
  output logic global_interrupt_enable
);
  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  initial begin
    if (PC_W < 9 || PC_W > 16) $error("PC_W out of range");
    if (STACK_D < 1 || STACK_D > 16) $error("STACK_D out of range");
  end
  localparam int SP_W = $clog2(STACK_D + 1);
  // --------------------------------------------------------------------
  // instruction cycle divider
  // --------------------------------------------------------------------
  logic [1:0] phase_ff;
  wire last_phase = (phase_ff == 2'(`MICT_CLK_PER_ICYC - 1));
  // phase counter; state only moves on the last phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) phase_ff <= 2'h0;
    else phase_ff <= phase_ff + 2'h1; // [RQ1]
  end
  assign icyc_strobe = last_phase; // [RQ1]
  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  mict_state_t state_ff, nxt_state;
  logic [PC_W-1:0] pc_ff, nxt_pc;
  logic [7:0] acc_ff, nxt_acc;
  logic carry_ff, nxt_carry;
  logic zero_ff, nxt_zero;
  logic gie_ff, nxt_gie;
  logic [SP_W-1:0] sp_ff, nxt_sp;
  logic [PC_W-1:0] stack_ff [STACK_D];
  // --------------------------------------------------------------------
  // alu
  // --------------------------------------------------------------------
  mict_alu_if alu_bus ();
  mict_alu u_alu (.a(alu_bus.alu));
  assign alu_bus.op = instr_op;
  assign alu_bus.acc = acc_ff;
  assign alu_bus.mem = instr_use_imm ? instr_imm : dmem_rdata;
  assign alu_bus.bit_sel = instr_bit;
  assign alu_bus.carry_in = carry_ff;
  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  function automatic logic is_two_cyc(mict_op_t op);
    return op == MICT_OP_JMP || op == MICT_OP_CALL ||
      op == MICT_OP_RET || op == MICT_OP_INTERRUPT_RETURN_INSTR || op == MICT_OP_TBRD;
  endfunction : is_two_cyc
  function automatic logic writes_mem(mict_op_t op);
    return !(op == MICT_OP_NOP || is_two_cyc(op) ||
      op == MICT_OP_SZ || op == MICT_OP_SNZ);
  endfunction : writes_mem
  wire executing = (state_ff == MICT_ST_EXEC);
  wire [PC_W-1:0] pc_inc = pc_ff + PC_W'(1);
  wire mem_dest = writes_mem(instr_op) && !instr_to_acc && !instr_use_imm;
  wire pcl_write = mem_dest && (instr_addr == `MICT_PCL_ADDR); // [RQ3]
  wire skip_take = (instr_op == MICT_OP_SZ && dmem_rdata == 8'h00) ||
    (instr_op == MICT_OP_SNZ && dmem_rdata != 8'h00); // [RQ4]
  wire need_flush = is_two_cyc(instr_op) || pcl_write || skip_take;
  wire stk_full = (sp_ff == SP_W'(STACK_D));
  wire stk_empty = (sp_ff == SP_W'(0));
  wire [SP_W-1:0] sp_dec = sp_ff - SP_W'(1);
  wire [PC_W-1:0] stk_top = stack_ff[stk_empty ? 0 : sp_dec];
  wire push = last_phase && executing && instr_op == MICT_OP_CALL
    && !stk_full; // [RQ10]
  // data memory port, read-modify-write in a single pass
  assign dmem_addr = instr_addr;
  assign dmem_sector = `MICT_SECTOR0; // [RQ12]
  assign dmem_wdata = alu_bus.result; // [RQ9]
  assign dmem_we = last_phase && executing && mem_dest; // [RQ9]
  assign tbl_addr = {instr_target[PC_W-1:8], acc_ff}; // [RQ11]
  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_acc = acc_ff;
    nxt_carry = carry_ff;
    nxt_zero = zero_ff;
    nxt_gie = gie_ff;
    nxt_sp = sp_ff;
    case (state_ff)
      MICT_ST_EXEC: begin
        nxt_pc = pc_inc;
        if (need_flush) nxt_state = MICT_ST_FLUSH; // [RQ2] [RQ14]
        if (alu_bus.carry_upd) nxt_carry = alu_bus.carry_out; // [RQ6]
        if (alu_bus.zero_upd) nxt_zero = alu_bus.zero_out; // [RQ5]
        if (writes_mem(instr_op) && (instr_to_acc || instr_use_imm))
          nxt_acc = alu_bus.result;
        case (instr_op)
          MICT_OP_JMP: nxt_pc = instr_target; // [RQ10]
          MICT_OP_CALL: begin
            nxt_pc = instr_target;
            if (!stk_full) nxt_sp = sp_ff + SP_W'(1); // [RQ10]
          end
          MICT_OP_RET, MICT_OP_INTERRUPT_RETURN_INSTR: begin
            nxt_pc = stk_top; // [RQ10]
            if (!stk_empty) nxt_sp = sp_dec;
            if (instr_op == MICT_OP_INTERRUPT_RETURN_INSTR) nxt_gie = 1'b1; // [RQ13]
          end
          MICT_OP_TBRD: nxt_acc = tbl_rdata; // [RQ11]
          MICT_OP_SZ, MICT_OP_SNZ: if (skip_take) nxt_pc = pc_ff + PC_W'(2);
          default: if (pcl_write)
            nxt_pc = {pc_inc[PC_W-1:8], alu_bus.result}; // [RQ3]
        endcase
      end
      MICT_ST_FLUSH: nxt_state = MICT_ST_EXEC; // [RQ14]
      default: nxt_state = MICT_ST_EXEC;
    endcase
  end
  // --------------------------------------------------------------------
  // state registers, updated once per instruction cycle
  // --------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= MICT_ST_EXEC;
      pc_ff <= PC_W'(`MICT_PC_RST);
      acc_ff <= 8'h00;
      carry_ff <= `MICT_CARRY_RST;
      zero_ff <= 1'b0;
      gie_ff <= `MICT_GIE_RST;
      sp_ff <= '0;
    end else if (last_phase) begin // [RQ1]
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      acc_ff <= nxt_acc;
      carry_ff <= nxt_carry;
      zero_ff <= nxt_zero;
      gie_ff <= nxt_gie;
      sp_ff <= nxt_sp;
    end
  end
  // return stack; a full stack drops the push rather than wrap
  generate
    for (genvar i = 0; i < STACK_D; i++) begin : g_stk
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) stack_ff[i] <= '0;
        else if (push && sp_ff == SP_W'(i)) stack_ff[i] <= pc_inc;
      end
    end
  endgenerate
  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign pc = pc_ff;
  assign flush = !executing; // [RQ14]
  assign acc = acc_ff;
  assign carry = carry_ff;
  assign zero = zero_ff;
  assign global_interrupt_enable = gie_ff;
endmodule : mict_core

// File: dv/mict_core_props.sv
`timescale 1ns/1ps
`include "mict_consts.svh"
module mict_core_props
  import mict_pkg::*;
#(
  parameter int PC_W = 13
)(
  // watched ports
  input wire logic clock,
  input wire logic rst_n,
  input wire mict_op_t instr_op,
  input wire logic [7:0] instr_addr,
  input wire logic instr_to_acc,
  input wire logic [PC_W-1:0] instr_target,
  input wire logic [7:0] dmem_rdata,
  input wire logic [1:0] dmem_sector,
  input wire logic [PC_W-1:0] pc,
  input wire logic icyc_strobe,
  input wire logic flush,
  input wire logic [7:0] acc,
  input wire logic global_interrupt_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // inputs during a flush cycle are ignored
  wire logic take = icyc_strobe && !flush;
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  strobe_gap_a: assert property (icyc_strobe |=> !icyc_strobe [*3] ##1 icyc_strobe)
    else $error("strobe spacing wrong");
  pc_hold_a: assert property (!icyc_strobe |=> $stable(pc))
    else $error("pc moved inside a cycle");
  jump_flush_a: assert property (take && instr_op == MICT_OP_JMP |=> flush [*4] ##1 !flush)
    else $error("flush length wrong");
  jump_target_a: assert property (take && instr_op == MICT_OP_JMP |=> pc == $past(instr_target))
    else $error("jump target wrong");
  pc_low_write_a: assert property (take && instr_op == MICT_OP_MOVM && !instr_to_acc && instr_addr == `MICT_PCL_ADDR |=> flush)
    else $error("pc low write not flushed");
  inc_value_a: assert property (take && instr_op == MICT_OP_INC && instr_to_acc |=> acc == $past(dmem_rdata) + 8'h01)
    else $error("increment wrong");
  int_return_a: assert property (take && instr_op == MICT_OP_INTERRUPT_RETURN_INSTR |=> global_interrupt_enable)
    else $error("enable not set");
  sub_return_a: assert property (take && instr_op == MICT_OP_RET |=> $stable(global_interrupt_enable))
    else $error("enable changed");
  sector_zero_a: assert property (dmem_sector == `MICT_SECTOR0)
    else $error("sector not zero");
  // main scenarios
  cover property (take && instr_op == MICT_OP_JMP);
  cover property (take && instr_op == MICT_OP_SZ);
  cover property (take && instr_op == MICT_OP_INTERRUPT_RETURN_INSTR);
endmodule : mict_core_props

bind mict_core mict_core_props #(.PC_W(PC_W)) u_props (.clock(clock),
  .rst_n(rst_n), .instr_op(instr_op), .instr_addr(instr_addr),
  .instr_to_acc(instr_to_acc), .instr_target(instr_target),
  .dmem_rdata(dmem_rdata), .dmem_sector(dmem_sector), .pc(pc),
  .icyc_strobe(icyc_strobe), .flush(flush), .acc(acc),
  .global_interrupt_enable(global_interrupt_enable));

// File: dv/mcu_instruction_cycle_timing_tb.sv
`timescale 1ns/1ps
module mcu_instruction_cycle_timing_tb;
  import mict_pkg::*;
  // ------------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------------
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  mict_op_t instr_op = MICT_OP_NOP;
  logic [7:0] instr_addr = 8'h00, instr_imm = 8'h00, dmem_rdata = 8'h00;
  logic [7:0] tbl_rdata = 8'h5a, dmem_addr, dmem_wdata, acc, wd_t;
  logic [2:0] instr_bit = 3'h0;
  logic instr_use_imm = 1'b0, instr_to_acc = 1'b1, dmem_we, we_t;
  logic [12:0] instr_target = 13'h0000, tbl_addr, pc, pc_t, ta_t;
  logic [1:0] dmem_sector;
  logic icyc_strobe, flush, carry, zero, global_interrupt_enable;
  int error_cnt = 0, n_checks = 0;

  always #2 clock = ~clock;

  mict_core uut (.clock(clock), .rst_n(rst_n), .instr_op(instr_op),
    .instr_addr(instr_addr), .instr_imm(instr_imm), .instr_bit(instr_bit),
    .instr_use_imm(instr_use_imm), .instr_to_acc(instr_to_acc),
    .instr_target(instr_target), .dmem_rdata(dmem_rdata),
    .dmem_addr(dmem_addr), .dmem_sector(dmem_sector),
    .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .tbl_rdata(tbl_rdata),
    .tbl_addr(tbl_addr), .pc(pc), .icyc_strobe(icyc_strobe),
    .flush(flush), .acc(acc), .carry(carry), .zero(zero),
    .global_interrupt_enable(global_interrupt_enable));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task chk(string what, logic [12:0] e, logic [12:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : chk

  // bounded wait for the edge that takes an instruction; strobe and the
  // combinational outputs are read at the falling edge, where they settle
  task sync;
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (icyc_strobe !== 1'b1 && n < 16);
    if (n >= 16) chk("strobe", 13'h1, 13'h0);
    pc_t = pc;
    wd_t = dmem_wdata;
    we_t = dmem_we;
    ta_t = tbl_addr;
    @(posedge clock);
  endtask : sync

  // one instruction for one whole cycle, then a nop cycle after it
  task issue(mict_op_t op, logic [7:0] a, m, logic [2:0] b, logic ta,
             logic [12:0] tg);
    sync();
    instr_op <= op;
    instr_addr <= a;
    dmem_rdata <= m;
    instr_bit <= b;
    instr_to_acc <= ta;
    instr_target <= tg;
    sync();
    instr_op <= MICT_OP_NOP;
    #1;
  endtask : issue

  task alu(mict_op_t op, logic [7:0] m, ea);
    issue(op, 8'h20, m, 3'h0, 1'b1, 13'h0000);
    chk("acc", {5'h00, ea}, {5'h00, acc});
  endtask : alu

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task t_cycle;
    time t;
    sync();
    t = $time;
    sync();
    chk("strobe gap", 13'h10, 13'($time - t));
    chk("sector", 13'h0, {11'h000, dmem_sector});
  endtask : t_cycle

  task t_data;
    alu(MICT_OP_AND, 8'hff, 8'h00);
    chk("zero", 13'h1, zero);
    alu(MICT_OP_OR, 8'h3c, 8'h3c);
    chk("zero", 13'h0, zero);
    alu(MICT_OP_XOR, 8'h3c, 8'h00);
    chk("zero", 13'h1, zero);
    alu(MICT_OP_CPL, 8'hf0, 8'h0f);
    chk("zero", 13'h0, zero);
    alu(MICT_OP_AND, 8'hf0, 8'h00);
    alu(MICT_OP_ADD, 8'hff, 8'hff);
    alu(MICT_OP_ADD, 8'h01, 8'h00);
    chk("carry", 13'h1, carry);
    alu(MICT_OP_SUB, 8'h01, 8'hff);
    chk("carry", 13'h0, carry);
    alu(MICT_OP_INC, 8'h7f, 8'h80);
    alu(MICT_OP_DEC, 8'h00, 8'hff);
    alu(MICT_OP_RRC, 8'h01, 8'h00);
    chk("carry", 13'h1, carry);
    alu(MICT_OP_RLC, 8'h80, 8'h01);
    chk("carry", 13'h1, carry);
    alu(MICT_OP_RR, 8'h01, 8'h80);
    alu(MICT_OP_RL, 8'h80, 8'h01);
    issue(MICT_OP_BSET, 8'h20, 8'ha5, 3'h1, 1'b0, 13'h0000);
    chk("set data", 13'ha7, wd_t);
    chk("set strobe", 13'h1, we_t);
    issue(MICT_OP_BCLR, 8'h20, 8'ha5, 3'h0, 1'b0, 13'h0000);
    chk("clear data", 13'ha4, wd_t);
  endtask : t_data

  // each step: op, address, data, bit, destination, target
  task t_flow;
    logic [12:0] ret_pc;
    issue(MICT_OP_JMP, 8'h20, 8'h00, 3'h0, 1'b1, 13'h0123);
    chk("jump pc", 13'h0123, pc);
    chk("jump flush", 13'h1, flush);
    issue(MICT_OP_CALL, 8'h20, 8'h00, 3'h0, 1'b1, 13'h0456);
    ret_pc = pc_t + 13'h1;
    chk("call pc", 13'h0456, pc);
    issue(MICT_OP_RET, 8'h20, 8'h00, 3'h0, 1'b1, 13'h0000);
    chk("return pc", ret_pc, pc);
    chk("return flush", 13'h1, flush);
    issue(MICT_OP_TBRD, 8'h20, 8'h00, 3'h0, 1'b1, 13'h0100);
    chk("table data", 13'h5a, acc);
    chk("table addr", 13'h0101, ta_t);
    chk("table flush", 13'h1, flush);
    issue(MICT_OP_INTERRUPT_RETURN_INSTR, 8'h20, 8'h00, 3'h0, 1'b1, 13'h0000);
    chk("enable", 13'h1, global_interrupt_enable);
    issue(MICT_OP_RET, 8'h20, 8'h00, 3'h0, 1'b1, 13'h0000);
    chk("enable kept", 13'h1, global_interrupt_enable);
    issue(MICT_OP_SZ, 8'h20, 8'h00, 3'h0, 1'b1, 13'h0000);
    chk("skip taken", 13'h1, flush);
    chk("skip pc", pc_t + 13'h2, pc);
    issue(MICT_OP_SZ, 8'h20, 8'h01, 3'h0, 1'b1, 13'h0000);
    chk("skip not taken", 13'h0, flush);
    issue(MICT_OP_SNZ, 8'h20, 8'h01, 3'h0, 1'b1, 13'h0000);
    chk("skip nonzero", 13'h1, flush);
    issue(MICT_OP_MOVM, 8'h06, 8'h00, 3'h0, 1'b0, 13'h0000);
    chk("pc low write", 13'h1, flush);
    issue(MICT_OP_MOVM, 8'h07, 8'h00, 3'h0, 1'b0, 13'h0000);
    chk("plain write", 13'h0, flush);
  endtask : t_flow

  task finish_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  // watchdog: the whole run needs about 0.94 microseconds
  initial begin
    #20000;
    error_cnt++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_cycle();
    t_data();
    t_flow();
    finish_test();
  end
endmodule : mcu_instruction_cycle_timing_tb
